/* verilog/gs_status_bank.sv */
/*
  Gripper status register bank with the picking sequencer that feeds it:
  activation, go-to moves, contact detection, brake, re-grasp, faults.
  Assumes command bytes arrive already decoded on ref_clk_i and that the
  frame layer issues one-cycle word reads at bus register addresses.
*/
`include "gs_map.svh"

// Contract
// - activation echo copies activation command, zero while in reset
// - go-to echo copies go-to command, zero until activation done
// - motion state: 0 reset, 1 activating, 3 activation done
// - object codes: 0 moving, 1 open contact, 2 close contact, 3 at target
// - status byte 0: object 7:6, motion 5:4, go-to 3, activation 0
// - fault 5: action before activation done; 7: action without activation
// - fault 8 on over-temperature, fault 9 after one second without traffic
// - major faults 0xa-0xf latch until activation rising edge
// - LED blue for none or priority, red minor, blinking major
// - status byte 3 echoes requested position
// - status byte 4 holds encoder finger position
// - status byte 5 holds instantaneous motor current sample
// - re-grasp disabled for zero force request, enabled otherwise
// - re-grasp closes toward requested position, stops on reaching it
// - re-grasp never exceeds host force and speed settings
// - object result cleared when a new go-to move starts; left at 3 when re-grasp starts
// - brake engages at move end, released between; same cycle as detection report
// - go-to moves until contact or requested position, whichever first
// - after close contact, object loss changes field to 3
// - addresses big-endian, register data bytes high byte first
// - current over force-derived limit stops fingers and flags object
// - first status register 0x07d0 packs bytes 0 and 1, then pairs
module gs_status_bank
  import gs_pkg::*;
#(
  parameter int unsigned COMM_TIMEOUT_CYC = `GS_COMM_TIMEOUT_CYC,
  parameter int unsigned BLINK_CYC        = `GS_BLINK_CYC,
  parameter int unsigned ACT_CYC          = 1000,
  parameter logic [7:0]  REGRASP_SPEED    = 8'h40,
  parameter logic [7:0]  REGRASP_FORCE    = 8'h80
) (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // decoded command bytes
  input  wire logic        activation_command_i,
  input  wire logic        goto_command_i,
  input  wire logic [7:0]  target_position_i,
  input  wire logic [7:0]  speed_request_i,
  input  wire logic [7:0]  force_request_i,
  input  wire logic        comm_frame_i,
  input  wire logic [3:0]  external_controller_fault_i,
  // word read port
  input  wire logic        rd_en_i,
  input  wire logic [15:0] rd_addr_i,
  output logic             rd_valid_o,
  output logic             rd_err_o,
  output logic [15:0]      rd_data_o,
  // sensor pins
  input  wire logic [7:0]  enc_position_i,
  input  wire logic [7:0]  motor_current_i,
  input  wire logic        over_temp_i,
  input  wire logic        under_volt_i,
  input  wire logic        internal_err_i,
  input  wire logic        over_current_i,
  // actuator and indicator
  output logic             motor_run_o,
  output logic             motor_close_o,
  output logic [7:0]       motor_speed_o,
  output logic [7:0]       motor_current_limit_o,
  output logic             brake_o,
  output logic             led_blue_o,
  output logic             led_red_o
);
  gs_sense_if sense ();

  gs_act_t     act_q;
  gs_move_t    mv_q;
  logic        act_cmd_q;
  logic        goto_cmd_q;
  logic [31:0] act_cnt_q;
  logic [31:0] comm_cnt_q;
  logic [31:0] blink_cnt_q;
  logic        blink_q;
  logic        comm_lost_q;
  logic [3:0]  major_q;
  logic [1:0]  obj_q;
  logic [1:0]  obj_pend_q;
  logic [7:0]  tgt_q;
  logic [7:0]  contact_pos_q;
  logic        activation_echo_q;
  logic        goto_echo_q;
  logic        act_rise;
  logic        act_done;
  logic        move_req;
  logic        regrasp_en;
  logic        over_limit;
  logic [7:0]  limit_now;
  logic [3:0]  major_new;
  logic [3:0]  fault_now;
  logic [1:0]  sta_now;
  logic [7:0]  state_byte;
  logic [7:0]  fault_byte;
  logic [15:0] word_ofs;
  logic [3:0]  byte_lo;

  gs_sense_sync u_sync (
    .ref_clk_i       (ref_clk_i),
    .reset_i         (reset_i),
    .enc_position_i  (enc_position_i),
    .motor_current_i (motor_current_i),
    .fault_pins_i    ({over_current_i, internal_err_i, under_volt_i,
                       over_temp_i}),
    .sense           (sense.src)
  );

  // command edges and move request
  assign act_rise   = activation_command_i & ~act_cmd_q;
  assign act_done   = (act_q == ACT_DONE);
  assign move_req   = act_done && goto_command_i && major_q == 4'h0 &&
                      (!goto_cmd_q || target_position_i != tgt_q);
  assign regrasp_en = (force_request_i != 8'h00);
  assign limit_now  = (mv_q == MV_REGRASP && REGRASP_FORCE < force_request_i)
                      ? REGRASP_FORCE : force_request_i;
  assign over_limit = (sense.current > limit_now);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      act_cmd_q  <= 1'b0;
      goto_cmd_q <= 1'b0;
    end else begin
      act_cmd_q  <= activation_command_i;
      goto_cmd_q <= goto_command_i;
    end
  end

  // activation sequencer
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      act_q     <= ACT_OFF;
      act_cnt_q <= 32'h0;
    end else if (!activation_command_i) begin
      act_q     <= ACT_OFF;
      act_cnt_q <= 32'h0;
    end else begin
      case (act_q)
        ACT_OFF: begin
          if (act_rise) begin
            act_q     <= ACT_RUN;
            act_cnt_q <= 32'h0;
          end
        end
        ACT_RUN: begin
          if (act_cnt_q >= ACT_CYC - 1) begin
            act_q <= ACT_DONE;
          end else begin
            act_cnt_q <= act_cnt_q + 32'h1;
          end
        end
        default: act_q <= act_q;
      endcase
    end
  end

  // motion sequencer, object result and brake
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mv_q          <= MV_IDLE;
      obj_q         <= `GS_OBJ_MOVING;
      obj_pend_q    <= `GS_OBJ_MOVING;
      tgt_q         <= 8'h00;
      contact_pos_q <= 8'h00;
    end else if (!act_done || !goto_command_i || major_q != 4'h0) begin
      mv_q <= MV_IDLE; // stop: fingers held on the brake
    end else if (move_req) begin
      mv_q  <= MV_RUN;
      tgt_q <= target_position_i;
      obj_q <= `GS_OBJ_MOVING;
    end else begin
      case (mv_q)
        MV_RUN, MV_REGRASP: begin
          if (sense.position == tgt_q) begin
            mv_q       <= MV_BRAKE;
            obj_pend_q <= `GS_OBJ_AT_TARGET;
          end else if (over_limit) begin
            mv_q          <= MV_BRAKE;
            contact_pos_q <= sense.position;
            obj_pend_q    <= (tgt_q > sense.position) ?
                             `GS_OBJ_CLOSE_HIT : `GS_OBJ_OPEN_HIT;
          end
        end
        MV_BRAKE: begin
          mv_q  <= MV_HELD; // brake set in the same cycle as the report
          obj_q <= obj_pend_q;
        end
        MV_HELD: begin
          if (obj_q == `GS_OBJ_CLOSE_HIT &&
              sense.position != contact_pos_q) begin
            obj_q <= `GS_OBJ_AT_TARGET; // object lost
            if (regrasp_en) begin
              mv_q <= MV_REGRASP;
            end
          end
        end
        default: mv_q <= MV_IDLE;
      endcase
    end
  end

  // actuator drive
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      motor_run_o           <= 1'b0;
      motor_close_o         <= 1'b0;
      motor_speed_o         <= 8'h00;
      motor_current_limit_o <= 8'h00;
      brake_o               <= 1'b1;
    end else begin
      motor_run_o   <= (mv_q == MV_RUN || mv_q == MV_REGRASP);
      brake_o       <= !(mv_q == MV_RUN || mv_q == MV_REGRASP);
      motor_close_o <= (tgt_q > sense.position);
      motor_current_limit_o <= limit_now;
      if (mv_q == MV_REGRASP && REGRASP_SPEED < speed_request_i) begin
        motor_speed_o <= REGRASP_SPEED;
      end else begin
        motor_speed_o <= speed_request_i;
      end
    end
  end

  // communication watchdog
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      comm_cnt_q  <= 32'h0;
      comm_lost_q <= 1'b0;
    end else if (comm_frame_i) begin
      comm_cnt_q  <= 32'h0;
      comm_lost_q <= 1'b0;
    end else if (comm_cnt_q >= COMM_TIMEOUT_CYC - 1) begin
      comm_lost_q <= 1'b1;
    end else begin
      comm_cnt_q <= comm_cnt_q + 32'h1;
    end
  end

  // major fault latch, a new fault wins over the clearing edge
  assign major_new = sense.under_volt   ? `GS_FLT_UNDER_VOLT :
                     sense.internal_err ? `GS_FLT_INTERNAL :
                     sense.over_current ? `GS_FLT_OVER_CUR : 4'h0;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      major_q <= 4'h0;
    end else if (major_new != 4'h0 && (major_q == 4'h0 || act_rise)) begin
      major_q <= major_new;
    end else if (act_rise) begin
      major_q <= 4'h0;
    end
  end

  // fault selection: major, then minor, then priority
  always_comb begin
    if (major_q != 4'h0) begin
      fault_now = major_q;
    end else if (sense.over_temp) begin
      fault_now = `GS_FLT_OVER_TEMP;
    end else if (comm_lost_q) begin
      fault_now = `GS_FLT_NO_COMM;
    end else if (goto_command_i && !activation_command_i) begin
      fault_now = `GS_FLT_NOT_ACTIVE;
    end else if (goto_command_i && !act_done) begin
      fault_now = `GS_FLT_ACT_PENDING;
    end else begin
      fault_now = `GS_FLT_NONE;
    end
  end

  // blink divider for the fault indicator
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q >= BLINK_CYC - 1) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end

  // fault indicator colours
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      led_blue_o <= 1'b1;
      led_red_o  <= 1'b0;
    end else if (major_q != 4'h0) begin
      led_blue_o <= blink_q;
      led_red_o  <= ~blink_q;
    end else if (fault_now == `GS_FLT_OVER_TEMP ||
                 fault_now == `GS_FLT_NO_COMM) begin
      led_blue_o <= 1'b0;
      led_red_o  <= 1'b1;
    end else begin
      led_blue_o <= 1'b1;
      led_red_o  <= 1'b0;
    end
  end

  // command echoes
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      activation_echo_q <= 1'b0;
      goto_echo_q       <= 1'b0;
    end else begin
      activation_echo_q <= activation_command_i;
      goto_echo_q       <= goto_command_i && act_done;
    end
  end

  // status byte assembly
  always_comb begin
    case (act_q)
      ACT_RUN:  sta_now = `GS_STA_ACTIVATING;
      ACT_DONE: sta_now = `GS_STA_DONE;
      default:  sta_now = `GS_STA_RESET;
    endcase
    state_byte = 8'h00;
    state_byte[`GS_OBJ_LSB +: 2] = obj_q;
    state_byte[`GS_STA_LSB +: 2] = sta_now;
    state_byte[`GS_GTO_BIT]      = goto_echo_q;
    state_byte[`GS_ACT_BIT]      = activation_echo_q;
    fault_byte = {external_controller_fault_i, fault_now};
  end

  // status byte by offset, reserved bytes read zero
  function automatic logic [7:0] status_byte(input logic [3:0] ofs);
    if (ofs == `GS_OFS_STATE) begin
      status_byte = state_byte;
    end else if (ofs == `GS_OFS_FAULT) begin
      status_byte = fault_byte;
    end else if (ofs == `GS_OFS_TGT_ECHO) begin
      status_byte = target_position_i;
    end else if (ofs == `GS_OFS_POSITION) begin
      status_byte = sense.position;
    end else if (ofs == `GS_OFS_CURRENT) begin
      status_byte = sense.current;
    end else begin
      status_byte = 8'h00;
    end
  endfunction

  assign word_ofs = rd_addr_i - `GS_STATUS_BASE;
  assign byte_lo  = {word_ofs[2:0], 1'b0};

  // word read, even byte goes out first
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rd_valid_o <= 1'b0;
      rd_err_o   <= 1'b0;
      rd_data_o  <= 16'h0000;
    end else if (rd_en_i) begin
      rd_valid_o <= 1'b1;
      if (rd_addr_i >= `GS_STATUS_BASE &&
          rd_addr_i <= `GS_STATUS_LAST) begin
        rd_err_o  <= 1'b0;
        rd_data_o <= {status_byte(byte_lo),
                      status_byte(byte_lo | 4'h1)};
      end else begin
        rd_err_o  <= 1'b1;
        rd_data_o <= 16'h0000;
      end
    end else begin
      rd_valid_o <= 1'b0;
      rd_err_o   <= 1'b0;
    end
  end
endmodule // gs_status_bank

/* verilog/gs_map.svh */
/*
  Offsets, field positions, codes and timing counts of the gripper
  status bank. Assumes a 10 MHz ref_clk_i.
*/
`ifndef GS_MAP_SVH
`define GS_MAP_SVH

// bus word addresses of the status area
`define GS_STATUS_BASE     16'h07d0
`define GS_STATUS_LAST     16'h07d7

// status byte offsets
`define GS_OFS_STATE       4'h0
`define GS_OFS_RSVD        4'h1
`define GS_OFS_FAULT       4'h2
`define GS_OFS_TGT_ECHO    4'h3
`define GS_OFS_POSITION    4'h4
`define GS_OFS_CURRENT     4'h5

// field positions in gripper_state
`define GS_OBJ_LSB         6
`define GS_STA_LSB         4
`define GS_GTO_BIT         3
`define GS_ACT_BIT         0

// motion state codes
`define GS_STA_RESET       2'h0
`define GS_STA_ACTIVATING  2'h1
`define GS_STA_DONE        2'h3

// object detection codes
`define GS_OBJ_MOVING      2'h0
`define GS_OBJ_OPEN_HIT    2'h1
`define GS_OBJ_CLOSE_HIT   2'h2
`define GS_OBJ_AT_TARGET   2'h3

// fault codes
`define GS_FLT_NONE        4'h0
`define GS_FLT_ACT_PENDING 4'h5
`define GS_FLT_NOT_ACTIVE  4'h7
`define GS_FLT_OVER_TEMP   4'h8
`define GS_FLT_NO_COMM     4'h9
`define GS_FLT_UNDER_VOLT  4'ha
`define GS_FLT_INTERNAL    4'hc
`define GS_FLT_OVER_CUR    4'he

// timing
`define GS_CLK_HZ          10000000
`define GS_COMM_TIMEOUT_MS 1000
`define GS_COMM_TIMEOUT_CYC (`GS_COMM_TIMEOUT_MS * (`GS_CLK_HZ / 1000))
`define GS_BLINK_MS        250
`define GS_BLINK_CYC       (`GS_BLINK_MS * (`GS_CLK_HZ / 1000))

`endif

/* verilog/gs_pkg.sv */
/*
  Types shared by the gripper status bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package gs_pkg;
  // activation sequencer
  typedef enum logic [1:0] {ACT_OFF, ACT_RUN, ACT_DONE} gs_act_t;
  // finger motion sequencer
  typedef enum logic [2:0] {
    MV_IDLE, MV_RUN, MV_BRAKE, MV_HELD, MV_REGRASP
  } gs_move_t;
endpackage

/* verilog/gs_sense_if.sv */
/*
  Synchronised sensor readings passed from the input stage to the bank.
  Assumes one clock for both ends.
*/
interface gs_sense_if;
  logic [7:0] position;
  logic [7:0] current;
  logic       over_temp;
  logic       under_volt;
  logic       internal_err;
  logic       over_current;
  modport src (output position, current, over_temp, under_volt,
               internal_err, over_current);
  modport dst (input  position, current, over_temp, under_volt,
               internal_err, over_current);
endinterface

/* verilog/gs_sense_sync.sv */
/*
  Two-flop synchronisers for the sensor pins, with a stability filter
  on the byte-wide readings so a torn sample is never passed on.
  Assumes the pins change slowly relative to ref_clk_i.
*/
module gs_sense_sync (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] enc_position_i,
  input  wire logic [7:0] motor_current_i,
  input  wire logic [3:0] fault_pins_i,
  gs_sense_if.src         sense
);
  logic [19:0] meta_q;
  logic [19:0] sync_q;
  logic [15:0] prev_q;

  // two flops per pin
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      meta_q <= 20'h00000;
      sync_q <= 20'h00000;
    end else begin
      meta_q <= {fault_pins_i, motor_current_i, enc_position_i};
      sync_q <= meta_q;
    end
  end

  // bytes are taken only when two samples agree
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      prev_q         <= 16'h0000;
      sense.position <= 8'h00;
      sense.current  <= 8'h00;
    end else begin
      prev_q <= sync_q[15:0];
      if (prev_q[7:0] == sync_q[7:0]) begin
        sense.position <= sync_q[7:0];
      end
      if (prev_q[15:8] == sync_q[15:8]) begin
        sense.current <= sync_q[15:8];
      end
    end
  end

  // fault levels straight from the second flop
  assign sense.over_temp    = sync_q[16];
  assign sense.under_volt   = sync_q[17];
  assign sense.internal_err = sync_q[18];
  assign sense.over_current = sync_q[19];
endmodule // gs_sense_sync

/* sim/gs_status_monitor.sv */
/*
  Port-level checker of the gripper status bank: read port answers,
  reserved bits, echoes, brake, indicator and re-grasp caps.
  Assumes one clock and a synchronous active-high reset.
*/
module gs_status_monitor (
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic        activation_command_i,
  input wire logic [7:0]  target_position_i,
  input wire logic [7:0]  speed_request_i,
  input wire logic [7:0]  force_request_i,
  input wire logic        rd_en_i,
  input wire logic [15:0] rd_addr_i,
  input wire logic        rd_valid_o,
  input wire logic        rd_err_o,
  input wire logic [15:0] rd_data_o,
  input wire logic        motor_run_o,
  input wire logic [7:0]  motor_speed_o,
  input wire logic [7:0]  motor_current_limit_o,
  input wire logic        brake_o,
  input wire logic        led_blue_o,
  input wire logic        led_red_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // address decode of the status area
  logic mapped;
  assign mapped = rd_addr_i >= 16'h07d0 && rd_addr_i <= 16'h07d7;

  // request of one word at a given address
  sequence s_rd_at(logic [15:0] a);
    rd_en_i && rd_addr_i == a;
  endsequence

  a_read_answer: assert property (rd_en_i |=> rd_valid_o)
    else $error("read not answered next cycle");
  a_valid_pulse: assert property (!rd_en_i |=> !rd_valid_o && !rd_err_o)
    else $error("answer without request");
  a_unmapped_err: assert property (rd_en_i && !mapped |=>
    rd_err_o && rd_data_o == 16'h0000)
    else $error("unmapped read not refused");
  a_mapped_ok: assert property (rd_en_i && mapped |=> !rd_err_o)
    else $error("mapped read refused");
  a_reserved_zero: assert property (s_rd_at(16'h07d0) |=>
    rd_data_o[7:0] == 8'h00 && rd_data_o[10:9] == 2'h0)
    else $error("reserved bits not zero");
  a_upper_words_zero: assert property (rd_en_i && mapped &&
    rd_addr_i >= 16'h07d3 |=> rd_data_o == 16'h0000)
    else $error("reserved bytes not zero");
  a_target_echo: assert property (s_rd_at(16'h07d1) |=>
    rd_data_o[7:0] == $past(target_position_i))
    else $error("target echo wrong");
  a_act_echo: assert property (s_rd_at(16'h07d0) ##0
    $stable(activation_command_i) |=>
    rd_data_o[8] == $past(activation_command_i))
    else $error("activation echo wrong");
  a_goto_needs_done: assert property (rd_valid_o &&
    $past(rd_addr_i) == 16'h07d0 && rd_data_o[11] |->
    rd_data_o[13:12] == 2'h3)
    else $error("go-to echo before activation done");
  a_brake_free_run: assert property (motor_run_o |-> !brake_o)
    else $error("brake engaged while moving");
  a_led_onehot: assert property ($onehot({led_blue_o, led_red_o}))
    else $error("indicator colours both or none");
  a_cap_limits: assert property (motor_run_o |->
    motor_current_limit_o <= force_request_i &&
    motor_speed_o <= speed_request_i)
    else $error("host force or speed exceeded");
endmodule // gs_status_monitor

bind gs_status_bank gs_status_monitor mon_u (
  .ref_clk_i, .reset_i, .activation_command_i, .target_position_i,
  .speed_request_i, .force_request_i, .rd_en_i, .rd_addr_i, .rd_valid_o,
  .rd_err_o, .rd_data_o, .motor_run_o, .motor_speed_o,
  .motor_current_limit_o, .brake_o, .led_blue_o, .led_red_o
);

/* sim/gs_host_model.sv */
/*
  Host model: issues one-word status reads and a periodic frame pulse.
  Assumes the bank answers one cycle after the request edge.
*/
module gs_host_model (
  input  wire logic        ref_clk_i,
  input  wire logic        rd_valid_i,
  input  wire logic [15:0] rd_data_i,
  input  wire logic        rd_err_i,
  output logic             rd_en_o,
  output logic [15:0]      rd_addr_o,
  output logic             frame_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic talking = 1'b1;

  // one word read; address released to its inverse afterwards
  task automatic read_word(input logic [15:0] addr,
                           output logic [15:0] data, output logic err);
    @(negedge ref_clk_i);
    rd_en_o   = 1'b1;
    rd_addr_o = addr;
    @(negedge ref_clk_i);
    rd_en_o   = 1'b0;
    rd_addr_o = ~addr;
    for (int i = 0; i < 3 && rd_valid_i !== 1'b1; i++) begin
      @(negedge ref_clk_i);
    end
    data = rd_valid_i === 1'b1 ? rd_data_i : 16'hxxxx;
    err  = rd_valid_i === 1'b1 ? rd_err_i : 1'bx;
  endtask

  // one frame every 50 cycles while talking
  initial begin
    rd_en_o   = 1'b0;
    rd_addr_o = 16'h0000;
    frame_o   = 1'b0;
    forever begin
      repeat (49) @(negedge ref_clk_i);
      frame_o = talking;
      @(negedge ref_clk_i);
      frame_o = 1'b0;
    end
  end
endmodule // gs_host_model

/* sim/gs_status_bank_bench.sv */
/*
  Self-checking bench of the gripper status bank with a host model;
  the bench plays the finger mechanics on the sensor pins.
  Assumes short counts for timeout, blink and activation.
*/
module gs_status_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] EXT = 4'h3;
  logic        ref_clk_i, reset_i, act, gto, frame, rd_en, rd_valid, rd_err;
  logic        ot, uv, ie, oc, run, close, brake, blue, red;
  logic [7:0]  tgt, spd, frc, enc, cur, mspd, lim;
  logic [15:0] rd_addr, rd_data;
  int          bad_count, num_checks;

  gs_status_bank #(.COMM_TIMEOUT_CYC(200), .BLINK_CYC(8), .ACT_CYC(30)) dut_u (
    .ref_clk_i, .reset_i, .activation_command_i(act), .goto_command_i(gto),
    .target_position_i(tgt), .speed_request_i(spd), .force_request_i(frc),
    .comm_frame_i(frame), .external_controller_fault_i(EXT),
    .rd_en_i(rd_en), .rd_addr_i(rd_addr), .rd_valid_o(rd_valid),
    .rd_err_o(rd_err), .rd_data_o(rd_data), .enc_position_i(enc),
    .motor_current_i(cur), .over_temp_i(ot), .under_volt_i(uv),
    .internal_err_i(ie), .over_current_i(oc), .motor_run_o(run),
    .motor_close_o(close), .motor_speed_o(mspd),
    .motor_current_limit_o(lim), .brake_o(brake), .led_blue_o(blue),
    .led_red_o(red));
  gs_host_model host_u (.ref_clk_i, .rd_valid_i(rd_valid),
    .rd_data_i(rd_data), .rd_err_i(rd_err), .rd_en_o(rd_en),
    .rd_addr_o(rd_addr), .frame_o(frame));

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input string what, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic chk_rd(input logic [15:0] a, exp, input logic err = 1'b0);
    logic [15:0] d;
    logic        e;
    host_u.read_word(a, d, e);
    check("read data", d, exp);
    check("read error", {15'h0, e}, {15'h0, err});
  endtask
  task automatic wait_brake();
    repeat (40) if (brake !== 1'b1) @(negedge ref_clk_i);
    cyc(3);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // idle outputs after reset and refused addresses
  task automatic t_reset_map();
    check("brake", {15'h0, brake}, 16'h1);
    check("leds", {14'h0, blue, red}, 16'h2);
    chk_rd(16'h07d0, 16'h0000);
    chk_rd(16'h07d5, 16'h0000);
    chk_rd(16'h07d8, 16'h0000, 1'b1);
    chk_rd(16'h07cf, 16'h0000, 1'b1);
  endtask
  // go-to refused before and during activation
  task automatic t_priority();
    gto = 1'b1;
    cyc(4);
    chk_rd(16'h07d1, {EXT, 4'h7, tgt});
    gto = 1'b0;
    act = 1'b1;
    cyc(3);
    gto = 1'b1;
    cyc(2);
    chk_rd(16'h07d0, 16'h1100);
    chk_rd(16'h07d1, {EXT, 4'h5, tgt});
    gto = 1'b0;
    cyc(40);
    chk_rd(16'h07d0, 16'h3100);
    chk_rd(16'h07d1, {EXT, 4'h0, tgt});
  endtask
  // plain move reaching the target
  task automatic t_move();
    gto = 1'b1;
    cyc(4);
    check("run", {14'h0, run, close}, 16'h3);
    check("limit", {mspd, lim}, {spd, frc});
    chk_rd(16'h07d0, 16'h3900);
    enc = 8'h80;
    wait_brake();
    chk_rd(16'h07d0, 16'hf900);
    chk_rd(16'h07d2, {8'h80, 8'h00});
  endtask
  // closing contact, loss and re-grasp with capped drive
  task automatic t_regrasp();
    gto = 1'b0;
    tgt = 8'hf0;
    spd = 8'hff;
    frc = 8'ha0;
    cyc(2);
    gto = 1'b1;
    cyc(4);
    cur = 8'hc0;
    wait_brake();
    chk_rd(16'h07d0, 16'hb900);
    chk_rd(16'h07d2, {8'h80, 8'hc0});
    cur = 8'h00;
    cyc(8);
    enc = 8'h90;
    repeat (40) if (run !== 1'b1) @(negedge ref_clk_i);
    check("regrasp run", {15'h0, run}, 16'h1);
    check("regrasp drive", {mspd, lim}, {8'h40, 8'h80});
    enc = 8'hf0;
    wait_brake();
    check("regrasp stop", {15'h0, run}, 16'h0);
  endtask
  // opening contact, then closing contact lost with zero force
  task automatic t_open_nofrc();
    gto = 1'b0;
    frc = 8'h00;
    tgt = 8'h00;
    cyc(2);
    gto = 1'b1;
    cyc(4);
    check("direction", {15'h0, close}, 16'h0);
    cur = 8'h01;
    wait_brake();
    chk_rd(16'h07d0, 16'h7900);
    gto = 1'b0;
    tgt = 8'hff;
    cyc(2);
    gto = 1'b1;
    cyc(10);
    chk_rd(16'h07d0, 16'hb900);
    cur = 8'h00;
    cyc(8);
    enc = 8'hf8;
    cyc(20);
    check("no regrasp", {15'h0, run}, 16'h0);
    chk_rd(16'h07d0, 16'hf900);
  endtask
  // minor, major and comm-loss faults with indicator
  task automatic t_faults();
    int n;
    n = 0;
    ot = 1'b1;
    cyc(8);
    chk_rd(16'h07d1, {EXT, 4'h8, tgt});
    check("led minor", {14'h0, blue, red}, 16'h1);
    ot = 1'b0;
    uv = 1'b1;
    cyc(8);
    uv = 1'b0;
    cyc(8);
    chk_rd(16'h07d1, {EXT, 4'ha, tgt});
    repeat (24) begin
      cyc(1);
      n += red;
    end
    check("blink", {15'h0, n > 4 && n < 20}, 16'h1);
    act = 1'b0;
    cyc(3);
    act = 1'b1;
    cyc(40);
    chk_rd(16'h07d1, {EXT, 4'h0, tgt});
    host_u.talking = 1'b0;
    cyc(260);
    chk_rd(16'h07d1, {EXT, 4'h9, tgt});
    check("led comm", {14'h0, blue, red}, 16'h1);
    host_u.talking = 1'b1;
    // first major held, then a major present at the clearing edge wins
    oc = 1'b1;
    cyc(8);
    ie = 1'b1;
    cyc(8);
    chk_rd(16'h07d1, {EXT, 4'he, tgt});
    act = 1'b0;
    cyc(3);
    act = 1'b1;
    cyc(2);
    chk_rd(16'h07d1, {EXT, 4'hc, tgt});
  endtask

  initial begin
    {reset_i, act, gto, ot, uv, ie, oc} = 7'h40;
    {tgt, spd, frc, enc, cur} = {8'h80, 8'h90, 8'h20, 8'h10, 8'h00};
    cyc(4);
    reset_i = 1'b0;
    cyc(4);
    t_reset_map();
    t_priority();
    t_move();
    t_regrasp();
    t_open_nofrc();
    t_faults();
    tally_and_finish();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    bad_count++;
    tally_and_finish();
  end
endmodule // gs_status_bank_bench
